// [hw/sfc_map.vh]
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// register byte offsets
`define SFC_OFS_IRQ_STATUS 8'h00
`define SFC_OFS_IRQ_ENABLE 8'h04
`define SFC_OFS_IRQ_CLEAR  8'h08
`define SFC_OFS_STATUS     8'h0C
`define SFC_OFS_CONTROL    8'h10
`define SFC_OFS_MAIN_FEAT  8'h20
`define SFC_OFS_EXT_FEAT   8'h34
`define SFC_OFS_LATCH_CNT  8'h40
`define SFC_OFS_IDENT      8'h44

// main feature bits
`define SFC_MF_AUTO_START  0
`define SFC_MF_AUTO_STOP   1
`define SFC_MF_WDOG_EN     2
`define SFC_MF_MODE_LO     3
`define SFC_MF_MODE_HI     4
`define SFC_MF_RAMP_EXP    5
`define SFC_MF_INV_FB      6
`define SFC_MF_LATCH_CLR   8
`define SFC_MF_MULTI_LATCH 9
`define SFC_MF_ENC_FB      11
`define SFC_MF_MASK        16'h0B7F
`define SFC_MF_RESET       16'h0804

// extended feature bits
`define SFC_XF_DECEL       1
`define SFC_XF_LATCH_POS   2
`define SFC_XF_SHOW_IDLE   3
`define SFC_XF_INV_DIN1    14
`define SFC_XF_INV_DIN2    15
`define SFC_XF_MASK        16'hC00E
`define SFC_XF_RESET       16'h0000

// control bits
`define SFC_CT_AUTO_STOP   0
`define SFC_CT_ESTOP       1
`define SFC_CT_LATCH_EN    2
`define SFC_CT_LATCH_RST   3

// operating modes
`define SFC_MODE_VEL_DIRECT 2'h0
`define SFC_MODE_VEL_RAMPS  2'h1
`define SFC_MODE_POS_TRACK  2'h2
`define SFC_MODE_PATH       2'h3

// interrupt bits
`define SFC_IRQ_WDOG       0
`define SFC_IRQ_ESTOP      1
`define SFC_IRQ_CNT_CLR    2

`define SFC_LATCH_CNT_MAX   5'h14
`define SFC_LATCH_CNT_RESET 5'h14
`define SFC_WDOG_MS         100
`define SFC_CLK_KHZ         250000

`endif

// [hw/sfc_feature_config.v]
`include "sfc_map.vh"

// Operation
// - mode from main feature bits 4:3
// - bit 5 picks linear or exponential ramps
// - exponential only while motion command runs
// - bit 2 enables watchdog, on by default
// - no process data over 100ms stops motor
// - auto-start, auto-stop, decel only path mode
// - latch event clears counter when enabled
// - multi-latch stores up to latch count
// - extended bits 14,15 invert digital inputs
// - extended bit 2 enables position latching
// - extended bit 3 reports idle status
// - main bit 6 inverts position feedback
// - main bit 11 selects encoder feedback
// - latch count defaults 20, max 20
// - auto-stop input edge gives emergency stop
module sfc_feature_config #(
    parameter WDOG_CYCLES = `SFC_WDOG_MS * `SFC_CLK_KHZ,
    parameter [15:0] IDENT_CODE = 16'h5A5A
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        din1,
    input  wire        din2,
    input  wire        latch_in,
    input  wire        pd_strobe,
    input  wire        motion_cmd_active,
    input  wire        motor_idle,
    output reg  [1:0]  op_mode,
    output reg         ramp_exp,
    output reg         auto_start_en,
    output reg         auto_stop_en,
    output reg         decel_en,
    output reg         wdog_stop,
    output reg         emergency_stop,
    output reg         counter_clear,
    output reg         latch_store,
    output reg         latch_pos_en,
    output reg         multi_latch_en,
    output reg  [4:0]  latch_depth,
    output reg         din1_eff,
    output reg         din2_eff,
    output reg         idle_status,
    output reg         invert_feedback,
    output reg         encoder_sel,
    output reg         irq
);

    // IDENT_CODE value is arbitrary

    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    function wr_hit;
        input       en;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = en & (addr == ofs);
        end
    endfunction

    reg [15:0] main_feature_config_reg;
    reg [15:0] extended_feature_config_reg;
    reg [4:0]  latch_count_reg;
    reg [2:0]  control_reg;
    reg [2:0]  irq_status_reg;
    reg [2:0]  irq_enable_reg;
    reg [4:0]  latch_stored_reg;
    reg [24:0] wdog_cnt_reg;
    reg        wdog_trip_reg;
    reg [2:0]  din1_sync_reg;
    reg [2:0]  din2_sync_reg;
    reg [2:0]  latch_sync_reg;
    reg        estop_prev_reg;
    reg        din1_prev_reg;
    reg        din2_prev_reg;

    wire        setup_ph = psel & ~penable;
    wire        wr_en    = psel & penable & pready & pwrite;
    wire [1:0]  mode     = {main_feature_config_reg[`SFC_MF_MODE_HI],
                            main_feature_config_reg[`SFC_MF_MODE_LO]};
    wire        path     = (mode == `SFC_MODE_PATH);
    wire        wdog_on  = main_feature_config_reg[`SFC_MF_WDOG_EN];

    // inputs after two synchroniser stages; inversion for break contacts
    // writing an inversion bit looks like an input edge to auto-stop
    wire din1_n = din1_sync_reg[1]
                  ^ extended_feature_config_reg[`SFC_XF_INV_DIN1];
    wire din2_n = din2_sync_reg[1]
                  ^ extended_feature_config_reg[`SFC_XF_INV_DIN2];
    wire latch_ev = rise(latch_sync_reg[1], latch_sync_reg[2]);

    wire auto_stop_arm = path & control_reg[`SFC_CT_AUTO_STOP]
                       & main_feature_config_reg[`SFC_MF_AUTO_STOP];
    wire din_edge = rise(din1_n, din1_prev_reg)
                  | rise(din2_n, din2_prev_reg);
    wire estop_ev = (auto_stop_arm & din_edge)
                  | rise(control_reg[`SFC_CT_ESTOP], estop_prev_reg);
    wire clr_ev   = latch_ev & control_reg[`SFC_CT_LATCH_EN]
                  & main_feature_config_reg[`SFC_MF_LATCH_CLR];
    wire multi    = main_feature_config_reg[`SFC_MF_MULTI_LATCH];
    wire store_ok = ~multi | (latch_stored_reg < latch_count_reg);
    wire store_ev = latch_ev & control_reg[`SFC_CT_LATCH_EN]
                  & extended_feature_config_reg[`SFC_XF_LATCH_POS]
                  & store_ok;
    // trip one cycle past WDOG_CYCLES, strictly more than the interval
    wire wdog_ev  = wdog_on & ~wdog_trip_reg & ~pd_strobe
                  & (wdog_cnt_reg >= WDOG_CYCLES[24:0]);

    wire [2:0] ev_vec;
    assign ev_vec[`SFC_IRQ_WDOG]    = wdog_ev;
    assign ev_vec[`SFC_IRQ_ESTOP]   = estop_ev;
    assign ev_vec[`SFC_IRQ_CNT_CLR] = clr_ev;

    wire clr_wr  = wr_hit(wr_en, paddr, `SFC_OFS_IRQ_CLEAR);
    wire lrst_wr = wr_hit(wr_en, paddr, `SFC_OFS_CONTROL)
                 & pwdata[`SFC_CT_LATCH_RST];
    // a new event wins over a clear in the same cycle
    wire [2:0] irq_kept = clr_wr ? (irq_status_reg & ~pwdata[2:0])
                                 : irq_status_reg;
    wire [2:0] irq_status_next = irq_kept | ev_vec;

    // clamp on the whole word so that large writes cannot wrap
    wire [4:0] wr_cnt = (pwdata > {27'h000_0000, `SFC_LATCH_CNT_MAX}) ?
                        `SFC_LATCH_CNT_MAX : pwdata[4:0];

    reg [31:0] rdata_next;
    reg        rerr_next;
    always @* begin
        rdata_next = 32'h0000_0000;
        rerr_next  = 1'b0;
        case (paddr)
            `SFC_OFS_IRQ_STATUS: rdata_next[2:0] = irq_status_reg;
            `SFC_OFS_IRQ_ENABLE: rdata_next[2:0] = irq_enable_reg;
            `SFC_OFS_IRQ_CLEAR:  rdata_next = 32'h0000_0000;
            `SFC_OFS_STATUS:     rdata_next[10:0] = {latch_stored_reg,
                                 idle_status, din2_eff, din1_eff,
                                 wdog_trip_reg, mode};
            `SFC_OFS_CONTROL:    rdata_next[2:0] = control_reg;
            `SFC_OFS_MAIN_FEAT:  rdata_next[15:0] =
                                 main_feature_config_reg;
            `SFC_OFS_EXT_FEAT:   rdata_next[15:0] =
                                 extended_feature_config_reg;
            `SFC_OFS_LATCH_CNT:  rdata_next[4:0] = latch_count_reg;
            `SFC_OFS_IDENT:      rdata_next[15:0] = IDENT_CODE;
            default:             rerr_next = 1'b1;
        endcase
    end

    // apb: answer one cycle after setup, zero wait states
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= setup_ph;
            if (setup_ph) begin
                pslverr <= rerr_next;
                prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // software registers; unmapped writes are dropped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_feature_config_reg     <= `SFC_MF_RESET;
            extended_feature_config_reg <= `SFC_XF_RESET;
            latch_count_reg             <= `SFC_LATCH_CNT_RESET;
            control_reg                 <= 3'h0;
            irq_enable_reg              <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                `SFC_OFS_MAIN_FEAT: main_feature_config_reg <=
                    pwdata[15:0] & `SFC_MF_MASK;
                `SFC_OFS_EXT_FEAT: extended_feature_config_reg <=
                    pwdata[15:0] & `SFC_XF_MASK;
                `SFC_OFS_LATCH_CNT: latch_count_reg <= wr_cnt;
                `SFC_OFS_CONTROL: control_reg <= pwdata[2:0];
                `SFC_OFS_IRQ_ENABLE: irq_enable_reg <= pwdata[2:0];
                default: control_reg <= control_reg;
            endcase
        end
    end

    // irq follows the next status so that a clear drops it at once
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= 3'h0;
            irq            <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq            <= |(irq_status_next & irq_enable_reg);
        end
    end

    // input synchronisers and edge history
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            din1_sync_reg  <= 3'h0;
            din2_sync_reg  <= 3'h0;
            latch_sync_reg <= 3'h0;
            din1_prev_reg  <= 1'b0;
            din2_prev_reg  <= 1'b0;
            estop_prev_reg <= 1'b0;
        end else begin
            din1_sync_reg  <= {din1_sync_reg[1:0], din1};
            din2_sync_reg  <= {din2_sync_reg[1:0], din2};
            latch_sync_reg <= {latch_sync_reg[1:0], latch_in};
            din1_prev_reg  <= din1_n;
            din2_prev_reg  <= din2_n;
            estop_prev_reg <= control_reg[`SFC_CT_ESTOP];
        end
    end

    // process data watchdog; a trip holds until data arrives again or the watchdog is disabled
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_cnt_reg  <= 25'h000_0000;
            wdog_trip_reg <= 1'b0;
        end else if (pd_strobe || !wdog_on) begin
            wdog_cnt_reg  <= 25'h000_0000;
            wdog_trip_reg <= 1'b0;
        end else begin
            if (wdog_cnt_reg < WDOG_CYCLES[24:0])
                wdog_cnt_reg <= wdog_cnt_reg + 25'h000_0001;
            if (wdog_ev)
                wdog_trip_reg <= 1'b1;
        end
    end

    // count of stored latch values
    // latch count 0 stores nothing in multi mode
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_stored_reg <= 5'h00;
        end else if (!multi || lrst_wr) begin
            latch_stored_reg <= 5'h00;
        end else if (store_ev) begin
            latch_stored_reg <= latch_stored_reg + 5'h01;
        end
    end

    // registered outputs toward the motion logic
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_mode         <= `SFC_MODE_VEL_DIRECT;
            ramp_exp        <= 1'b0;
            auto_start_en   <= 1'b0;
            auto_stop_en    <= 1'b0;
            decel_en        <= 1'b0;
            wdog_stop       <= 1'b0;
            emergency_stop  <= 1'b0;
            counter_clear   <= 1'b0;
            latch_store     <= 1'b0;
            latch_pos_en    <= 1'b0;
            multi_latch_en  <= 1'b0;
            latch_depth     <= `SFC_LATCH_CNT_RESET;
            din1_eff        <= 1'b0;
            din2_eff        <= 1'b0;
            idle_status     <= 1'b0;
            invert_feedback <= 1'b0;
            encoder_sel     <= 1'b1;
        end else begin
            op_mode        <= mode;
            ramp_exp       <= path & motion_cmd_active
                & main_feature_config_reg[`SFC_MF_RAMP_EXP];
            auto_start_en  <= path
                & main_feature_config_reg[`SFC_MF_AUTO_START];
            auto_stop_en   <= auto_stop_arm;
            decel_en       <= path
                & extended_feature_config_reg[`SFC_XF_DECEL];
            wdog_stop      <= wdog_trip_reg | wdog_ev;
            emergency_stop <= estop_ev;
            counter_clear  <= clr_ev;
            latch_store    <= store_ev;
            latch_pos_en   <=
                extended_feature_config_reg[`SFC_XF_LATCH_POS];
            multi_latch_en <= multi;
            latch_depth    <= multi ? latch_count_reg : 5'h01;
            din1_eff       <= din1_n;
            din2_eff       <= din2_n;
            idle_status    <= motor_idle
                & extended_feature_config_reg[`SFC_XF_SHOW_IDLE];
            invert_feedback <= main_feature_config_reg[`SFC_MF_INV_FB];
            encoder_sel    <= main_feature_config_reg[`SFC_MF_ENC_FB];
        end
    end

endmodule

// [tb/sfc_fieldbus_model.sv]
module sfc_fieldbus_model #(
    parameter int PERIOD = 20
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      pd_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg;
    // refresh process data well inside the watchdog interval
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= 8'h00;
            pd_strobe <= 1'b0;
        end else begin
            cnt_reg   <= (cnt_reg == PERIOD - 1) ? 8'h00 : cnt_reg + 8'h01;
            pd_strobe <= run && (cnt_reg == PERIOD - 1);
        end
    end
endmodule

// [tb/sfc_feature_config_properties.sv]
module sfc_feature_config_properties #(
    parameter WDOG_CYCLES = 50
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pd_strobe,
    input wire logic       motor_idle,
    input wire logic [1:0] op_mode,
    input wire logic       ramp_exp,
    input wire logic       auto_start_en,
    input wire logic       auto_stop_en,
    input wire logic       decel_en,
    input wire logic       wdog_stop,
    input wire logic       emergency_stop,
    input wire logic       counter_clear,
    input wire logic       latch_store,
    input wire logic [4:0] latch_depth,
    input wire logic       idle_status
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] gap_reg;
    // cycles since the last process data refresh
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) gap_reg <= 32'h0000_0000;
        else gap_reg <= pd_strobe ? 32'h0000_0000 : gap_reg + 32'h0000_0001;
    end
    a_ramp_exp_path: assert property (ramp_exp |-> op_mode == 2'h3)
        else $error("exponential ramp outside path mode");
    a_path_only_features: assert property
        ((auto_start_en || auto_stop_en || decel_en) |-> op_mode == 2'h3)
        else $error("path feature active outside path mode");
    a_wdog_trip_time: assert property
        ($rose(wdog_stop) |-> gap_reg > WDOG_CYCLES)
        else $error("watchdog tripped early");
    a_wdog_release: assert property (pd_strobe |-> ##[1:2] !wdog_stop)
        else $error("watchdog stop held after refresh");
    a_estop_pulse: assert property (emergency_stop |=> !emergency_stop)
        else $error("emergency stop longer than one cycle");
    a_clear_pulse: assert property (counter_clear |=> !counter_clear)
        else $error("counter clear longer than one cycle");
    a_idle_cause: assert property (idle_status |-> $past(motor_idle))
        else $error("idle reported without idle motor");
    a_depth_max: assert property (latch_depth <= 5'h14)
        else $error("latch depth above maximum");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_store_pulse: assert property (latch_store |=> !latch_store)
        else $error("latch store longer than one cycle");
    a_ready_setup: assert property ((psel && !penable) |=> pready)
        else $error("no pready after setup");
endmodule

bind sfc_feature_config sfc_feature_config_properties #(
    .WDOG_CYCLES(WDOG_CYCLES)
) u_props (
    .clk(clk), .rst_n(rst_n), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .latch_store(latch_store),
    .pd_strobe(pd_strobe), .motor_idle(motor_idle), .op_mode(op_mode),
    .ramp_exp(ramp_exp), .auto_start_en(auto_start_en),
    .auto_stop_en(auto_stop_en), .decel_en(decel_en),
    .wdog_stop(wdog_stop), .emergency_stop(emergency_stop),
    .counter_clear(counter_clear), .latch_depth(latch_depth),
    .idle_status(idle_status)
);

// [tb/sfc_feature_config_tb_top.sv]
module sfc_feature_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] mf, xf, mf_rb, xf_rb;
        logic [11:0] outs;
    } sfc_row_t;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
    logic pready, pslverr, rd_err, din1 = 0, din2 = 0, latch_in = 0;
    logic motion = 0, idle = 0, run = 1, pd_strobe;
    logic [1:0] op_mode;
    logic ramp_exp, as_en, ast_en, dec_en, wdog_stop, estop, cnt_clr;
    logic lstore, lpos, multi, d1, d2, idle_st, inv_fb, enc, irq;
    logic [4:0] depth;
    int err_count = 0, n_compared = 0, n;
    sfc_row_t rows [4];
    always #2 clk = ~clk;
    sfc_fieldbus_model #(.PERIOD(20)) u_bus (.clk(clk), .rst_n(rst_n),
        .run(run), .pd_strobe(pd_strobe));
    sfc_feature_config #(.WDOG_CYCLES(50)) DUT (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din1(din1), .din2(din2), .latch_in(latch_in),
        .pd_strobe(pd_strobe), .motion_cmd_active(motion),
        .motor_idle(idle), .op_mode(op_mode), .ramp_exp(ramp_exp),
        .auto_start_en(as_en), .auto_stop_en(ast_en), .decel_en(dec_en),
        .wdog_stop(wdog_stop), .emergency_stop(estop),
        .counter_clear(cnt_clr), .latch_store(lstore),
        .latch_pos_en(lpos), .multi_latch_en(multi), .latch_depth(depth),
        .din1_eff(d1), .din2_eff(d2), .idle_status(idle_st),
        .invert_feedback(inv_fb), .encoder_sel(enc), .irq(irq));
    task final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin err_count++; final_report(); end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // wait for wdog_stop, emergency_stop, counter_clear or latch_store
    task wait_sig(input int s, input logic v, input int lim);
        logic [3:0] w;
        n = 0;
        w = {lstore, cnt_clr, estop, wdog_stop};
        while (w[s] !== v && n < lim) begin
            @(posedge clk);
            n++;
            w = {lstore, cnt_clr, estop, wdog_stop};
        end
        if (n >= lim) begin err_count++; final_report(); end
    endtask
    initial begin
        rows[0] = '{16'hFFFF, 16'hFFFF, 16'h0B7F, 16'hC00E, 12'hFFF};
        rows[1] = '{16'h002B, 16'h0002, 16'h002B, 16'h0002, 12'h400};
        rows[2] = '{16'h0050, 16'h4004, 16'h0050, 16'h4004, 12'h81A};
        rows[3] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 12'h000};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk("enc_sel", enc, 1);
        chk("depth", depth, 1);
        chk("mode", op_mode, 0);
        apb(0, 8'h20, 0); chk("main_rst", rd_data, 32'h0000_0804);
        apb(0, 8'h34, 0); chk("ext_rst", rd_data, 32'h0000_0000);
        apb(0, 8'h40, 0); chk("cnt_rst", rd_data, 32'h0000_0014);
        apb(1, 8'h10, 32'h0000_0001);
        motion <= 1'b1;
        foreach (rows[i]) begin
            apb(1, 8'h20, {16'h0000, rows[i].mf});
            apb(1, 8'h34, {16'h0000, rows[i].xf});
            repeat (4) @(posedge clk);
            apb(0, 8'h20, 0); chk("main_rb", rd_data, rows[i].mf_rb);
            apb(0, 8'h34, 0); chk("ext_rb", rd_data, rows[i].xf_rb);
            chk("outs", {op_mode, ramp_exp, as_en, ast_en, dec_en, multi, lpos,
        inv_fb, enc, d1, d2}, rows[i].outs);
        end
        apb(1, 8'h20, 32'h0000_0004);
        apb(1, 8'h04, 32'h0000_0001);
        run <= 1'b0;
        wait_sig(0, 1, 300); chk("wd_late", n >= 30, 1);
        @(posedge clk);
        chk("irq_on", irq, 1);
        apb(0, 8'h00, 0); chk("wd_stat", rd_data[0], 1);
        apb(1, 8'h08, 32'h0000_0001);
        apb(0, 8'h00, 0); chk("wd_clr", rd_data[0], 0);
        chk("irq_off", irq, 0);
        run <= 1'b1;
        wait_sig(0, 0, 60);
        apb(1, 8'h20, 32'h0000_0000);
        run <= 1'b0;
        repeat (120) @(posedge clk);
        chk("wd_off", wdog_stop, 0);
        run <= 1'b1;
        apb(1, 8'h20, 32'h0000_001A);
        apb(1, 8'h10, 32'h0000_0001);
        din1 <= 1'b1;
        wait_sig(1, 1, 10);
        din2 <= 1'b1;
        @(posedge clk);
        din1 <= 1'b0;
        wait_sig(1, 1, 10);
        motion <= 1'b0;
        apb(1, 8'h20, 32'h0000_0038);
        repeat (2) @(posedge clk);
        chk("ramp_manual", ramp_exp, 0);
        motion <= 1'b1;
        repeat (2) @(posedge clk);
        chk("ramp_cmd", ramp_exp, 1);
        apb(1, 8'h20, 32'h0000_0100);
        apb(1, 8'h10, 32'h0000_0004);
        latch_in <= 1'b1;
        wait_sig(2, 1, 10);
        idle <= 1'b1;
        repeat (3) @(posedge clk);
        chk("idle_hidden", idle_st, 0);
        apb(1, 8'h34, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk("idle", idle_st, 1);
        apb(0, 8'h80, 0);
        chk("unmapped_err", rd_err, 1);
        chk("unmapped_data", rd_data, 0);
        apb(1, 8'h40, 32'h0000_0019);
        apb(0, 8'h40, 0); chk("cnt_clamp", rd_data, 32'h0000_0014);
        apb(1, 8'h40, 32'h0000_0003);
        apb(1, 8'h20, 32'h0000_0200);
        repeat (2) @(posedge clk);
        chk("depth_multi", depth, 3);
        apb(1, 8'h08, 32'h0000_0002);
        apb(1, 8'h10, 32'h0000_0002);
        wait_sig(1, 1, 10);
        apb(0, 8'h00, 0); chk("estop_stat", rd_data[1], 1);
        apb(1, 8'h34, 32'h0000_0004);
        apb(1, 8'h10, 32'h0000_0004);
        latch_in <= 1'b0;
        repeat (4) @(posedge clk);
        latch_in <= 1'b1;
        wait_sig(3, 1, 10);
        repeat (3) begin
            latch_in <= 1'b0;
            repeat (4) @(posedge clk);
            latch_in <= 1'b1;
            repeat (6) @(posedge clk);
        end
        apb(0, 8'h0C, 0); chk("stored", rd_data[10:6], 3);
        apb(0, 8'h44, 0); chk("ident", rd_data, 32'h0000_5A5A);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk("depth_rst", depth, 1);
        apb(0, 8'h20, 0); chk("main_rst2", rd_data, 32'h0000_0804);
        final_report();
    end
endmodule
